//--- design/ltg_top.sv
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "ltg_map.svh"

// Notes on behaviour
// RULE1: select internal or external trigger source
// RULE2: chained sub-board runs with external source
// RULE3: external mode waits programmed start delay
// RULE4: unsupported start delay means zero delay
// RULE5: new settings apply only between cycles
// RULE6: internal cycles repeat at rate in hertz
// RULE7: acquisition starts delay after lamp
// RULE8: acquisition pulse has programmed length
// RULE9: Q-switch starts delay after acquisition
// RULE10: Q-switch pulse has programmed length
// RULE11: each pulse output has own enable
// RULE12: laser master: gate on after trigger
// RULE13: laser master: gate off after trigger
// RULE14: gate output only while gate enabled
// RULE15: laser slave: Q-switch delay after lamp
// RULE16: laser slave: gate on after Q-switch
// RULE17: laser slave: gate off after Q-switch
// RULE18: times are whole system clock counts
module ltg_top #(
  parameter bit START_DLY_EN = 1'b1,
  parameter logic [19:0] LAMP_LEN_US = `LTG_LAMP_LEN_US
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_trig,
  output ltg_pkg::ltg_pulse_type pulses
);
  import ltg_pkg::*;

  localparam int NRW = `LTG_NUM_RW;
  localparam int US_CYC = `LTG_US_CYC;
  localparam int I_CTRL = int'(`LTG_OFF_CTRL) / 4;
  localparam int I_REP = int'(`LTG_OFF_REP_HZ) / 4;
  localparam int I_SDLY = int'(`LTG_OFF_START_DLY) / 4;
  localparam int I_L2A = int'(`LTG_OFF_L2A) / 4;
  localparam int I_ACQ = int'(`LTG_OFF_ACQ_LEN) / 4;
  localparam int I_A2Q = int'(`LTG_OFF_A2Q) / 4;
  localparam int I_QLEN = int'(`LTG_OFF_Q_LEN) / 4;
  localparam int I_QDLY = int'(`LTG_OFF_QSW_DLY) / 4;
  localparam int I_GON = int'(`LTG_OFF_GATE_ON) / 4;
  localparam int I_GOFF = int'(`LTG_OFF_GATE_OFF) / 4;
  localparam int I_STAT = int'(`LTG_OFF_STATUS) / 4;

  // bus slave
  logic [31:0] regs_ff [NRW];
  logic wr_ff;
  logic nxt_wr;
  logic [3:0] widx_ff;
  logic [3:0] nxt_widx;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] status;
  logic take;
  logic mapped;
  logic [3:0] aidx;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign take = hsel & htrans[1] & hready;
  assign aidx = haddr[5:2];
  assign mapped = (haddr[31:6] == 26'h000_0000) && (int'(aidx) <= I_STAT);

  always_comb begin
    nxt_wr = take & hwrite & mapped & (int'(aidx) < NRW);
    nxt_widx = take ? aidx : widx_ff;
    nxt_rdata = rdata_ff;
    if (take && !hwrite) begin
      if (!mapped) begin
        nxt_rdata = 32'h0000_0000;
      end else if (int'(aidx) == I_STAT) begin
        nxt_rdata = status;
      end else begin
        nxt_rdata = regs_ff[aidx];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      widx_ff <= 4'h0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wr_ff <= nxt_wr;
      widx_ff <= nxt_widx;
      rdata_ff <= nxt_rdata;
    end
  end

  for (genvar i = 0; i < NRW; i++) begin : g_reg
    logic [31:0] nxt_r;
    always_comb begin
      nxt_r = regs_ff[i];
      if (wr_ff && widx_ff == 4'(i)) begin
        nxt_r = hwdata;
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        regs_ff[i] <= `LTG_RST_VAL;
      end else begin
        regs_ff[i] <= nxt_r;
      end
    end
  end

  // configuration staging
  ltg_cfg_type reg_cfg;
  ltg_cfg_type cfg_ff;
  ltg_cfg_type nxt_cfg;
  ltg_state_type state_ff;
  ltg_state_type nxt_state;
  logic start_ev;

  always_comb begin
    reg_cfg.ext = regs_ff[I_CTRL][`LTG_CTRL_EXT];
    reg_cfg.scn = ltg_scn_type'(regs_ff[I_CTRL][`LTG_CTRL_SCN +: 2]);
    reg_cfg.en = ltg_pulse_type'(regs_ff[I_CTRL][`LTG_CTRL_EN +: 4]);
    reg_cfg.rep_hz = regs_ff[I_REP];
    reg_cfg.start_dly = regs_ff[I_SDLY][19:0];
    reg_cfg.l2a = regs_ff[I_L2A][19:0];
    reg_cfg.acq_len = regs_ff[I_ACQ][19:0];
    reg_cfg.a2q = regs_ff[I_A2Q][19:0];
    reg_cfg.q_len = regs_ff[I_QLEN][19:0];
    reg_cfg.qsw_dly = regs_ff[I_QDLY][19:0];
    reg_cfg.gate_on = regs_ff[I_GON][19:0];
    reg_cfg.gate_off = regs_ff[I_GOFF][19:0];
    // RULE5: apply only when idle
    nxt_cfg = (state_ff == LTG_IDLE && !start_ev) ? reg_cfg : cfg_ff;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // trigger input synchroniser and edge
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic ext_edge;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= ext_trig;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign ext_edge = s2_ff & ~s3_ff;

  // source select and repetition accumulator
  logic ext_mode;
  logic int_tick;
  logic [31:0] acc_ff;
  logic [31:0] nxt_acc;
  logic [32:0] acc_sum;

  // RULE1: source select
  // RULE2: external source for chained boards
  assign ext_mode = (cfg_ff.scn == LTG_SCN_LMASTER) ||
                    (cfg_ff.ext && cfg_ff.scn != LTG_SCN_LSLAVE);

  always_comb begin
    acc_sum = {1'b0, acc_ff} + {1'b0, cfg_ff.rep_hz};
    int_tick = 1'b0;
    nxt_acc = acc_ff;
    if (ext_mode || cfg_ff.rep_hz == 32'h0000_0000) begin
      nxt_acc = 32'h0000_0000;
    // RULE6: rate in hertz
    // RULE18: next whole clock count
    end else if (acc_sum >= {1'b0, `LTG_CLK_HZ}) begin
      int_tick = 1'b1;
      nxt_acc = 32'(acc_sum - {1'b0, `LTG_CLK_HZ});
    end else begin
      nxt_acc = acc_sum[31:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= 32'h0000_0000;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  assign start_ev = ext_mode ? ext_edge : int_tick;

  // timing chain in microsecond steps
  logic [7:0] div_ff;
  logic [7:0] nxt_div;
  logic [19:0] t_ff;
  logic [19:0] nxt_t;
  logic us_tick;
  logic use_dly;

  assign us_tick = div_ff == 8'(US_CYC - 1);
  // RULE4: delay ignored when unsupported
  assign use_dly = START_DLY_EN && cfg_ff.start_dly != 20'h0_0000;

  logic [21:0] tt;
  logic [21:0] q_st;
  logic [21:0] g_ref;
  logic [21:0] acq_end;
  logic [21:0] q_end;
  logic [21:0] g_on;
  logic [21:0] g_off;
  logic [21:0] end_t;
  ltg_pulse_type win;
  ltg_pulse_type nxt_pulses;

  always_comb begin
    tt = {2'b00, t_ff};
    // RULE9: direct mode Q-switch after acquisition
    // RULE15: slave mode Q-switch after lamp
    q_st = (cfg_ff.scn == LTG_SCN_LSLAVE) ? {2'b00, cfg_ff.qsw_dly} :
           {2'b00, cfg_ff.l2a} + {2'b00, cfg_ff.a2q};
    // RULE12: master gate refers to trigger
    // RULE16: slave gate refers to Q-switch
    g_ref = (cfg_ff.scn == LTG_SCN_LMASTER) ? 22'h00_0000 : q_st;
    acq_end = {2'b00, cfg_ff.l2a} + {2'b00, cfg_ff.acq_len};
    q_end = q_st + {2'b00, cfg_ff.q_len};
    g_on = g_ref + {2'b00, cfg_ff.gate_on};
    g_off = g_ref + {2'b00, cfg_ff.gate_off};
    win.lamp = cfg_ff.scn != LTG_SCN_LMASTER && tt < {2'b00, LAMP_LEN_US};
    // RULE7: acquisition start
    // RULE8: acquisition length
    win.acq = cfg_ff.scn == LTG_SCN_DIRECT &&
              tt >= {2'b00, cfg_ff.l2a} && tt < acq_end;
    // RULE10: Q-switch length
    win.qsw = cfg_ff.scn != LTG_SCN_LMASTER && tt >= q_st && tt < q_end;
    // RULE13: gate off time
    // RULE17: gate off time
    win.gate = tt >= g_on && tt < g_off;
    end_t = {2'b00, LAMP_LEN_US};
    if (acq_end > end_t) begin
      end_t = acq_end;
    end
    if (q_end > end_t) begin
      end_t = q_end;
    end
    if (g_off > end_t) begin
      end_t = g_off;
    end
    // RULE11: per output enable
    // RULE14: gate enable
    nxt_pulses = (state_ff == LTG_RUN) ? (win & cfg_ff.en) : '0;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_t = t_ff;
    // RULE18: whole clock counts per microsecond
    nxt_div = us_tick ? 8'h00 : div_ff + 8'h01;
    case (state_ff)
      LTG_IDLE: begin
        nxt_div = 8'h00;
        nxt_t = 20'h0_0000;
        if (start_ev) begin
          // RULE3: wait start delay first
          nxt_state = (ext_mode && use_dly) ? LTG_WAIT : LTG_RUN;
        end
      end
      LTG_WAIT: begin
        if (us_tick) begin
          nxt_t = t_ff + 20'h0_0001;
          if (nxt_t == cfg_ff.start_dly) begin
            nxt_state = LTG_RUN;
            nxt_t = 20'h0_0000;
          end
        end
      end
      LTG_RUN: begin
        if (tt >= end_t) begin
          nxt_state = LTG_IDLE;
        end else if (us_tick) begin
          nxt_t = t_ff + 20'h0_0001;
        end
      end
      default: begin
        nxt_state = LTG_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= LTG_IDLE;
      div_ff <= 8'h00;
      t_ff <= 20'h0_0000;
      pulses <= '0;
    end else begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      t_ff <= nxt_t;
      pulses <= nxt_pulses;
    end
  end

  assign status = 32'({ext_mode, state_ff != LTG_IDLE, pulses});

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_ext_start;
    state_ff == LTG_IDLE && ext_mode && ext_edge;
  endsequence

  sequence s_int_start;
    state_ff == LTG_IDLE && !ext_mode && int_tick;
  endsequence

  a_src_ignore: assert property ( // RULE1
    (state_ff == LTG_IDLE && !ext_mode && !int_tick) |=>
    state_ff == LTG_IDLE)
    else $error("cycle started without internal tick");
  a_start_wait: assert property ( // RULE3
    (s_ext_start and use_dly) |=> state_ff == LTG_WAIT)
    else $error("external start skipped delay");
  a_wait_legal: assert property ( // RULE4
    state_ff == LTG_WAIT |-> START_DLY_EN && use_dly)
    else $error("delay used while unsupported");
  a_cfg_hold: assert property ( // RULE5
    state_ff != LTG_IDLE |=> $stable(cfg_ff))
    else $error("settings changed inside a cycle");
  a_cfg_start: assert property ( // RULE5
    (state_ff == LTG_IDLE && start_ev) |=> $stable(cfg_ff))
    else $error("settings changed at cycle start");
  a_int_start: assert property ( // RULE6
    s_int_start |=> state_ff == LTG_RUN ##1 pulses.lamp == cfg_ff.en.lamp)
    else $error("internal tick did not start lamp");
  a_acq_edges: assert property ( // RULE7
    $rose(pulses.acq) |-> $past(t_ff) == cfg_ff.l2a)
    else $error("acquisition start wrong");
  a_acq_len: assert property ( // RULE8
    $fell(pulses.acq) |-> {2'b00, $past(t_ff)} == acq_end)
    else $error("acquisition length wrong");
  a_qsw_start: assert property ( // RULE9
    $rose(pulses.qsw) |-> {2'b00, $past(t_ff)} == q_st)
    else $error("Q-switch start wrong");
  a_qsw_len: assert property ( // RULE10
    $fell(pulses.qsw) |-> {2'b00, $past(t_ff)} == q_end)
    else $error("Q-switch length wrong");
  a_pulse_en: assert property ( // RULE11
    (pulses & ~cfg_ff.en) == 4'h0)
    else $error("pulse on while switched off");
  a_gate_on: assert property ( // RULE12
    $rose(pulses.gate) |-> {2'b00, $past(t_ff)} == g_on)
    else $error("gate start wrong");
  a_gate_off: assert property ( // RULE13
    $fell(pulses.gate) |-> {2'b00, $past(t_ff)} == g_off)
    else $error("gate stop wrong");
  a_us_step: assert property ( // RULE18
    (state_ff == LTG_RUN && $past(state_ff) == LTG_RUN &&
     $changed(t_ff)) |-> $past(div_ff) == 8'(US_CYC - 1))
    else $error("time step not one microsecond");

endmodule

//--- design/ltg_map.svh
`ifndef LTG_MAP_SVH
`define LTG_MAP_SVH

// clock and time base
`define LTG_CLK_HZ 32'h0BEB_C200
`define LTG_CLK_NS 5
`define LTG_US_NS 1000
`define LTG_US_CYC (`LTG_US_NS / `LTG_CLK_NS)
`define LTG_LAMP_LEN_US 20'h0_000A

// register byte offsets
`define LTG_OFF_CTRL 8'h00
`define LTG_OFF_REP_HZ 8'h04
`define LTG_OFF_EXT_HZ 8'h08
`define LTG_OFF_START_DLY 8'h0C
`define LTG_OFF_L2A 8'h10
`define LTG_OFF_ACQ_LEN 8'h14
`define LTG_OFF_A2Q 8'h18
`define LTG_OFF_Q_LEN 8'h1C
`define LTG_OFF_QSW_DLY 8'h20
`define LTG_OFF_GATE_ON 8'h24
`define LTG_OFF_GATE_OFF 8'h28
`define LTG_OFF_STATUS 8'h2C
`define LTG_NUM_RW 11

// control field positions
`define LTG_CTRL_EXT 0
`define LTG_CTRL_SCN 1
`define LTG_CTRL_EN 3

// reset value of every writable register
`define LTG_RST_VAL 32'h0000_0000

`endif

//--- design/ltg_pkg.sv
package ltg_pkg;

  typedef enum logic [1:0] {
    LTG_IDLE,
    LTG_WAIT,
    LTG_RUN
  } ltg_state_type;

  typedef enum logic [1:0] {
    LTG_SCN_DIRECT,
    LTG_SCN_LMASTER,
    LTG_SCN_LSLAVE,
    LTG_SCN_RSVD
  } ltg_scn_type;

  typedef struct packed {
    logic lamp;
    logic acq;
    logic qsw;
    logic gate;
  } ltg_pulse_type;

  typedef struct packed {
    logic ext;
    ltg_scn_type scn;
    ltg_pulse_type en;
    logic [31:0] rep_hz;
    logic [19:0] start_dly;
    logic [19:0] l2a;
    logic [19:0] acq_len;
    logic [19:0] a2q;
    logic [19:0] q_len;
    logic [19:0] qsw_dly;
    logic [19:0] gate_on;
    logic [19:0] gate_off;
  } ltg_cfg_type;

endpackage

//--- dv/ltg_laser.sv
`timescale 1ns/1ps
module ltg_laser #(
  parameter int QW = 20
) (
  input wire logic hclk,
  input wire logic fire,
  output logic q_out
);
  int cnt = 0;
  // laser q-switch output, driven low between shots
  always @(posedge hclk) begin
    if (fire) begin
      cnt <= QW;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign q_out = (cnt > 0);
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
`include "ltg_map.svh"
module testbench;
  import ltg_pkg::*;
  localparam int US = `LTG_US_CYC;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } ltg_row_type;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic ext_trig;
  logic fire = 1'b0;
  ltg_pulse_type pulses;
  wire logic [4:0] mv = {pulses, ext_trig};
  logic [4:0] mprev = 5'h00;
  int cyc = 0;
  int errors = 0;
  int n_checks = 0;
  int rise[5];
  int fall[5];
  int nrise[5] = '{0, 0, 0, 0, 0};
  int nr[5];
  int lprev;
  int g0;
  int g1;
  logic [31:0] rd;
  ltg_row_type rows[6] = '{
    '{`LTG_OFF_EXT_HZ, 32'h1234_5678, 32'h1234_5678},
    '{`LTG_OFF_GATE_OFF, 32'h000A_5A5A, 32'h000A_5A5A},
    '{`LTG_OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_0000},
    '{8'h30, 32'h0000_0001, 32'h0000_0000},
    '{8'h40, 32'h0000_0001, 32'h0000_0000},
    '{`LTG_OFF_CTRL, 32'h0000_0001, 32'h0000_0001}};

  always #2.5 hclk = ~hclk;

  ltg_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_trig(ext_trig), .pulses(pulses));
  ltg_laser laser (.hclk(hclk), .fire(fire), .q_out(ext_trig));

  // edge times of lamp, acq, qsw, gate, trigger
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    mprev <= mv;
    for (int i = 0; i < 5; i++) begin
      if (mv[i] && !mprev[i]) begin
        nrise[i] <= nrise[i] + 1;
        rise[i] <= cyc;
        if (i == 4) begin
          lprev <= rise[4];
        end
      end
      if (!mv[i] && mprev[i]) begin
        fall[i] <= cyc;
      end
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic hwait();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      errors++;
      tally_and_finish();
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic wt(input int i, input logic lvl);
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      #1;
      k++;
    end while (mv[i] !== lvl && k < 30000);
    if (k >= 30000) begin
      errors++;
      tally_and_finish();
    end
    @(posedge hclk);
    #1;
  endtask

  // let the running cycle end first: triggers inside a cycle are ignored
  task automatic trig();
    repeat (`LTG_LAMP_LEN_US * US) @(posedge hclk);
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
  endtask

  task automatic master_run(input int on, output int g);
    trig();
    wt(1, 1'b1);
    wt(1, 1'b0);
    g = rise[1] - rise[0];
    chk(32'(fall[1] - rise[1]), 32'((3 - on) * US));
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      bus(8'(i * 4), 1'b0, 32'h0000_0000);
      chk(rd, `LTG_RST_VAL);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      bus(rows[i].a, 1'b0, 32'h0000_0000);
      chk(rd, rows[i].e);
    end
    $display("test regs done");
    wr(`LTG_OFF_L2A, 32'h0000_0001);
    wr(`LTG_OFF_ACQ_LEN, 32'h0000_0002);
    wr(`LTG_OFF_A2Q, 32'h0000_0001);
    wr(`LTG_OFF_Q_LEN, 32'h0000_0001);
    wr(`LTG_OFF_GATE_ON, 32'h0000_0001);
    wr(`LTG_OFF_GATE_OFF, 32'h0000_0003);
    wr(`LTG_OFF_CTRL, 32'h0000_0078);
    wr(`LTG_OFF_REP_HZ, 32'h0000_4E20);
    wt(4, 1'b1);
    wr(`LTG_OFF_L2A, 32'h0000_0005);
    wt(1, 1'b1);
    wt(1, 1'b0);
    chk(32'(rise[3] - rise[4]), 32'(US));
    chk(32'(fall[3] - rise[3]), 32'(2 * US));
    chk(32'(rise[2] - rise[3]), 32'(US));
    chk(32'(fall[2] - rise[2]), 32'(US));
    chk(32'(fall[1] - rise[1]), 32'(2 * US));
    wt(4, 1'b0);
    chk(32'(fall[4] - rise[4]), 32'(`LTG_LAMP_LEN_US * US));
    wt(4, 1'b1);
    chk(32'(rise[4] - lprev), 32'(200_000_000 / 20_000));
    wt(3, 1'b1);
    chk(32'(rise[3] - rise[4]), 32'(5 * US));
    $display("test direct done");
    wr(`LTG_OFF_CTRL, 32'h0000_0010);
    wt(1, 1'b1);
    wt(1, 1'b0);
    nr = nrise;
    wt(2, 1'b1);
    wt(2, 1'b0);
    repeat (3 * US) @(posedge hclk);
    chk(32'(nrise[4] - nr[4]), 32'h0000_0000);
    chk(32'(nrise[3] - nr[3]), 32'h0000_0000);
    chk(32'(nrise[1] - nr[1]), 32'h0000_0000);
    $display("test enables done");
    wr(`LTG_OFF_QSW_DLY, 32'h0000_0002);
    wr(`LTG_OFF_GATE_OFF, 32'h0000_0002);
    wr(`LTG_OFF_CTRL, 32'h0000_007C);
    nr = nrise;
    wt(4, 1'b1);
    wt(1, 1'b1);
    wt(1, 1'b0);
    chk(32'(rise[2] - rise[4]), 32'(2 * US));
    chk(32'(rise[1] - rise[2]), 32'(US));
    chk(32'(fall[1] - rise[1]), 32'(US));
    chk(32'(nrise[3] - nr[3]), 32'h0000_0000);
    wr(`LTG_OFF_REP_HZ, 32'h0000_0000);
    wt(4, 1'b0);
    $display("test slave done");
    wr(`LTG_OFF_GATE_OFF, 32'h0000_0003);
    // chained board runs from the outside trigger
    wr(`LTG_OFF_CTRL, 32'h0000_000A);
    master_run(1, g0);
    wr(`LTG_OFF_START_DLY, 32'h0000_0001);
    master_run(1, g1);
    chk(32'(g1 - g0), 32'(US));
    wr(`LTG_OFF_START_DLY, 32'h0000_0000);
    wr(`LTG_OFF_GATE_ON, 32'h0000_0002);
    master_run(2, g1);
    chk(32'(g1 - g0), 32'(US));
    $display("test master done");
    // outside trigger in direct timing, then reset inside the cycle
    wr(`LTG_OFF_CTRL, 32'h0000_0049);
    trig();
    wt(1, 1'b1);
    chk(32'(rise[1] - rise[4]), 32'((5 + 1 + 2) * US));
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    chk(32'(pulses), 32'h0000_0000);
    hresetn <= 1'b1;
    bus(`LTG_OFF_CTRL, 1'b0, 32'h0000_0000);
    chk(rd, `LTG_RST_VAL);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
